/* hw/predriver_control.sv */
`timescale 1ns/1ps
`default_nettype none
module predriver_control
	import predriver_pkg::*;
#(
	parameter logic [DEAD_WIDTH-1:0] DEAD_DEFAULT = DEAD_RESET
) (
	// core clock and reset
	input  wire logic                   clock,
	input  wire logic                   srst,
	// device reset pin and power-on good
	input  wire logic                   reset_n,
	input  wire logic                   supply_ok,
	// enables
	input  wire logic                   drive_enable_first,
	input  wire logic                   drive_enable_second,
	// phase commands
	input  wire logic                   phase_a_high_cmd_n,
	input  wire logic                   phase_a_low_cmd,
	input  wire logic                   phase_b_high_cmd_n,
	input  wire logic                   phase_b_low_cmd,
	input  wire logic                   phase_c_high_cmd_n,
	input  wire logic                   phase_c_low_cmd,
	// comparator and fault detectors
	input  wire logic [2:0]             phase_above_half,
	input  wire logic                   overcurrent_detect,
	input  wire logic [FAULT_WIDTH-2:0] fault_detect,
	// serial port
	input  wire logic                   sclk,
	input  wire logic                   cs_n,
	input  wire logic                   si,
	output var  logic                   so,
	output var  logic                   so_oe_n,
	// gate drives
	output var  logic [2:0]             high_side_driver,
	output var  logic [2:0]             low_side_driver,
	output var  logic                   gate_hiz,
	// status
	output var  logic                   phase_a_level_status,
	output var  logic                   phase_b_level_status,
	output var  logic                   phase_c_level_status,
	output var  logic                   overcurrent_status,
	output var  logic                   interrupt
);

	localparam int PIN_COUNT = 15 + FAULT_WIDTH - 1;

	logic [PIN_COUNT-1:0]   pin_raw;
	logic [PIN_COUNT-1:0]   pin_meta;
	logic [PIN_COUNT-1:0]   pin_s;
	logic                   reset_n_s;
	logic                   supply_ok_s;
	logic                   en_s;
	logic [2:0]             hi_req;
	logic [2:0]             lo_req;
	logic [2:0]             above_s;
	logic                   oc_s;
	logic [FAULT_WIDTH-2:0] fault_s;
	logic                   cs_n_s;
	logic                   cs_q;
	logic                   logic_rst;
	logic                   pins_enable;
	logic                   link_rst;
	logic                   cs_rise;
	logic                   frame_ok;
	logic [2:0]             opcode;
	logic                   clear_cmd;
	logic [MASK_WIDTH-1:0]  mask_first;
	logic [MASK_WIDTH-1:0]  mask_second;
	logic [DEAD_WIDTH-1:0]  deadtime;
	logic [DCNT_WIDTH-1:0]  dead_cycles;
	logic [FAULT_WIDTH-1:0] fault_live;
	logic [FRAME_BITS-1:0]  status;
	logic [2:0]             hi_drv;
	logic [2:0]             lo_drv;
	logic [2:0]             armed;

	link_if bus ();

	// ======================================================================
	// pin synchronisers
	assign pin_raw = {reset_n, supply_ok, drive_enable_first,
		drive_enable_second, phase_c_high_cmd_n, phase_b_high_cmd_n,
		phase_a_high_cmd_n, phase_c_low_cmd, phase_b_low_cmd,
		phase_a_low_cmd, phase_above_half, overcurrent_detect,
		fault_detect, cs_n};

	always_ff @(posedge clock) begin
		pin_meta <= pin_raw;
		pin_s    <= pin_meta;
	end

	// decoded synchronised pins
	assign reset_n_s   = pin_s[PIN_COUNT-1];
	assign supply_ok_s = pin_s[PIN_COUNT-2];
	assign en_s        = pin_s[PIN_COUNT-3] & pin_s[PIN_COUNT-4]; // [R1]
	assign hi_req      = ~pin_s[PIN_COUNT-5 -: 3]; // [R7]
	assign lo_req      = pin_s[PIN_COUNT-8 -: 3]; // [R8]
	assign above_s     = pin_s[PIN_COUNT-11 -: 3];
	assign oc_s        = pin_s[FAULT_WIDTH];
	assign fault_s     = pin_s[FAULT_WIDTH-1:1];
	assign cs_n_s      = pin_s[0];

	// logic reset from core reset, reset pin and power-on
	assign logic_rst = srst | ~reset_n_s | ~supply_ok_s; // [R5] [R6]

	// ======================================================================
	// asynchronous gate override from the pins themselves
	assign pins_enable = drive_enable_first & drive_enable_second &
		reset_n & supply_ok; // [R1] [R2] [R3] [R5]
	assign high_side_driver = hi_drv & {3{pins_enable}}; // [R3]
	assign low_side_driver  = lo_drv & {3{pins_enable}}; // [R3]
	assign gate_hiz         = ~supply_ok; // [R6]
	assign link_rst         = ~reset_n | ~supply_ok; // [R6]

	// ======================================================================
	// serial port in the serial clock domain
	spi_link link (
		.sclk     (sclk),
		.link_rst (link_rst),
		.cs_n     (cs_n),
		.si       (si),
		.so       (so),
		.so_oe_n  (so_oe_n),
		.bus      (bus.link)
	);

	// frame end detect; the word is quiet after chip select rises
	always_ff @(posedge clock) begin
		if (logic_rst)
			cs_q <= 1'b1;
		else
			cs_q <= cs_n_s;
	end

	assign cs_rise   = cs_n_s & ~cs_q; // [R18]
	assign frame_ok  = cs_rise && !logic_rst &&
		bus.bit_count == COUNT_WIDTH'(FRAME_BITS); // [R18]
	assign opcode    = bus.cmd_word[OP_MSB:OP_LSB];
	assign clear_cmd = frame_ok && opcode == OP_CLEAR_INT;

	// ======================================================================
	// command registers
	always_ff @(posedge clock) begin
		if (logic_rst) begin
			mask_first  <= MASK_RESET;
			mask_second <= MASK_RESET;
			deadtime    <= DEAD_DEFAULT;
		end else if (frame_ok) begin // [R18]
			unique case (opcode)
				OP_MASK_FIRST:  mask_first  <= bus.cmd_word[MASK_WIDTH-1:0]; // [R11]
				OP_MASK_SECOND: mask_second <= bus.cmd_word[MASK_WIDTH-1:0]; // [R11]
				OP_DEADTIME:    deadtime    <= bus.cmd_word[DEAD_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	assign dead_cycles = DCNT_WIDTH'(deadtime * DEAD_STEP_CYCLES);

	// ======================================================================
	// status outputs
	always_ff @(posedge clock) begin
		if (logic_rst) begin
			phase_a_level_status <= 1'b0;
			phase_b_level_status <= 1'b0;
			phase_c_level_status <= 1'b0;
			overcurrent_status   <= 1'b0;
		end else begin
			phase_a_level_status <= above_s[0]; // [R9]
			phase_b_level_status <= above_s[1]; // [R9]
			phase_c_level_status <= above_s[2]; // [R9]
			overcurrent_status   <= oc_s; // [R16]
		end
	end

	// ======================================================================
	// latched interrupt; a new fault wins over the clear
	assign fault_live = {fault_s, oc_s} & {mask_second, mask_first}; // [R11]

	always_ff @(posedge clock) begin
		if (logic_rst)
			interrupt <= 1'b0;
		else if (|fault_live)
			interrupt <= 1'b1; // [R10]
		else if (clear_cmd)
			interrupt <= 1'b0; // [R10]
	end

	// status byte, frozen while a frame is in progress
	always_ff @(posedge clock) begin
		if (logic_rst)
			status <= 8'h00;
		else if (cs_n_s) begin
			status <= 8'h00;
			status[STAT_INT] <= interrupt;
			status[STAT_OC]  <= overcurrent_status;
			status[STAT_LVL_LSB +: 3] <= {phase_c_level_status,
				phase_b_level_status, phase_a_level_status};
		end
	end

	assign bus.status_word = status;

	// ======================================================================
	// per-phase sequencing with deadtime and bootstrap arming
	for (genvar i = 0; i < 3; i++) begin : g_phase
		phase_state_type       state;
		logic                  side;
		logic                  hi_q;
		logic                  lo_q;
		logic                  sel_req;
		logic [DCNT_WIDTH-1:0] cnt;

		assign sel_req = side ? hi_req[i] : lo_req[i];

		// command edges restart the deadtime toward the new side
		always_ff @(posedge clock) begin
			if (logic_rst) begin
				state <= PH_IDLE;
				side  <= 1'b0;
				cnt   <= 8'h00;
				hi_q  <= 1'b0;
				lo_q  <= 1'b0;
			end else begin
				hi_q <= hi_req[i];
				lo_q <= lo_req[i];
				if (hi_req[i] && !hi_q) begin
					side  <= 1'b1; // [R17]
					state <= PH_DEAD;
					cnt   <= dead_cycles;
				end else if (lo_req[i] && !lo_q) begin
					side  <= 1'b0; // [R17]
					state <= PH_DEAD;
					cnt   <= dead_cycles;
				end else begin
					unique case (state)
						PH_IDLE: ;
						PH_DEAD: begin
							if (!sel_req)
								state <= PH_IDLE;
							else if (cnt == 8'h00)
								state <= PH_ON; // [R17]
							else
								cnt <= cnt - 8'h01;
						end
						PH_ON: begin
							if (!sel_req)
								state <= PH_IDLE;
						end
						default: state <= PH_IDLE;
					endcase
				end
			end
		end

		// driver registers; the old side drops on the clock after a new edge is seen, not after the deadtime
		always_ff @(posedge clock) begin
			if (logic_rst) begin
				hi_drv[i] <= 1'b0;
				lo_drv[i] <= 1'b0;
			end else begin
				hi_drv[i] <= state == PH_ON && side && hi_req[i] &&
					armed[i] && en_s; // [R2] [R4]
				lo_drv[i] <= state == PH_ON && !side && lo_req[i] &&
					en_s; // [R2]
			end
		end

		// bootstrap arming, lost whenever the enables drop
		always_ff @(posedge clock) begin
			if (logic_rst || !en_s)
				armed[i] <= 1'b0; // [R4]
			else if (lo_drv[i])
				armed[i] <= 1'b1; // [R4]
		end

		boot_order_a: assert property (@(posedge clock) // [R4]
			disable iff (srst)
			$rose(hi_drv[i]) |-> $past(armed[i]))
			else $error("high side on without a low side pulse");

		dead_drop_a: assert property (@(posedge clock) // [R17]
			disable iff (srst)
			(hi_req[i] && !hi_q) |=> ##1 !lo_drv[i])
			else $error("low side not dropped after high edge");

		high_pol_a: assert property (@(posedge clock) // [R7]
			disable iff (srst)
			hi_drv[i] |-> $past(hi_req[i]) && !$past(pin_s[PIN_COUNT-5+i-2]))
			else $error("high side on with command input high");

		low_pol_a: assert property (@(posedge clock) // [R8]
			disable iff (srst)
			lo_drv[i] |-> $past(lo_req[i]))
			else $error("low side on with command input low");
	end

	// ======================================================================
	// checks
	gate_enable_a: assert property (@(posedge clock) // [R1]
		(|high_side_driver || |low_side_driver) |->
		(drive_enable_first && drive_enable_second))
		else $error("gate on while an enable is low");

	reset_reach_a: assert property (@(posedge clock) // [R5]
		disable iff (srst)
		($fell(reset_n) ##1 !reset_n [*3]) |->
		(!interrupt && mask_first == MASK_RESET && hi_drv == 3'h0))
		else $error("logic not reset after reset pin low");

	por_hiz_a: assert property (@(posedge clock) // [R6]
		!supply_ok |-> (gate_hiz && so_oe_n))
		else $error("drivers not floated below power-on");

	level_track_a: assert property (@(posedge clock) // [R9]
		disable iff (logic_rst)
		!$past(logic_rst) |->
		phase_a_level_status == $past(phase_above_half[0], 3))
		else $error("phase status does not follow comparator");

	int_hold_a: assert property (@(posedge clock) // [R10]
		disable iff (logic_rst)
		(interrupt && !clear_cmd) |=> interrupt)
		else $error("interrupt dropped without clear");

	int_mask_a: assert property (@(posedge clock) // [R11]
		disable iff (logic_rst)
		$rose(interrupt) |-> $past(|fault_live))
		else $error("interrupt raised by a masked source");

	oc_track_a: assert property (@(posedge clock) // [R16]
		disable iff (logic_rst)
		!$past(logic_rst) |->
		overcurrent_status == $past(overcurrent_detect, 3))
		else $error("overcurrent status does not follow detector");

	frame_end_a: assert property (@(posedge clock) // [R18]
		disable iff (logic_rst)
		$changed(mask_first) |-> $past(cs_rise))
		else $error("command acted on outside frame end");

	int_seen_c:   cover property (@(posedge clock) $rose(interrupt));
	high_on_c:    cover property (@(posedge clock) $rose(hi_drv[0]));
	frame_take_c: cover property (@(posedge clock) clear_cmd && interrupt);

endmodule
`default_nettype wire

/* hw/predriver_pkg.sv */
// Notes on behaviour
// R1 - gate drives may turn on only while both enable inputs are high
// R2 - an enable low forces all gates off; logic and serial port keep running
// R3 - the enables force the gates off at once, without a clock edge
// R4 - after enable, a high side waits until its low side has been pulsed on
// R5 - reset pin low disables outputs and resets the logic within 77 ns
// R6 - below power-on threshold: logic in reset, drivers tri-stated, port deaf
// R7 - high-side command inputs are active low, idle high by pull-up
// R8 - low-side command inputs are active high, idle low by pull-down
// R9 - phase status is low while the phase source is under half of battery
// R10 - a fault drives the interrupt high until the serial clear command
// R11 - two serially written masks block each fault source from the interrupt
// R12 - the serial port answers only while chip select is low; it idles high
// R13 - serial input sampled on falling clock edges, most significant bit first
// R14 - the controller keeps the serial clock at or below 5 MHz, typically 3; the testbench mostly runs it at 31.25 MHz (16 ns half period)
// R15 - serial output floats while deselected; new bits appear on rising edges
// R16 - overcurrent status is high while overcurrent is present, low otherwise
// R17 - a command edge drops the other driver at once, selected after deadtime
// R18 - a frame completes at chip select rising; only then is it acted upon
`default_nettype none
package predriver_pkg;

	// ======================================================================
	// timing
	localparam int CLOCK_NS          = 25;
	localparam int RESET_ACT_NS      = 77;
	localparam int RESET_ACT_CYCLES  = RESET_ACT_NS / CLOCK_NS;
	localparam int DEAD_STEP_NS      = 50;
	localparam int DEAD_STEP_CYCLES  =
		(DEAD_STEP_NS + CLOCK_NS - 1) / CLOCK_NS;

	// ======================================================================
	// serial frame layout
	localparam int          FRAME_BITS   = 8;
	localparam int          COUNT_WIDTH  = 4;
	localparam int          OP_MSB       = 7;
	localparam int          OP_LSB       = 5;
	localparam int          MASK_WIDTH   = 4;
	localparam int          DEAD_WIDTH   = 5;
	localparam int          FAULT_WIDTH  = 2 * MASK_WIDTH;
	localparam int          DCNT_WIDTH   = 8;
	localparam logic [2:0]  OP_MASK_FIRST  = 3'h1;
	localparam logic [2:0]  OP_MASK_SECOND = 3'h2;
	localparam logic [2:0]  OP_CLEAR_INT   = 3'h3;
	localparam logic [2:0]  OP_DEADTIME    = 3'h4;

	// ======================================================================
	// reset values and status byte fields
	localparam logic [MASK_WIDTH-1:0] MASK_RESET = 4'hF;
	localparam logic [DEAD_WIDTH-1:0] DEAD_RESET = 5'h02;
	localparam int STAT_INT     = 7;
	localparam int STAT_OC      = 6;
	localparam int STAT_LVL_LSB = 3;

	// ======================================================================
	// per-phase driver sequencing
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_DEAD = 2'b01,
		PH_ON   = 2'b11
	} phase_state_type;

endpackage
`default_nettype wire

/* hw/link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// words passed between the serial clock domain and the core clock domain
interface link_if;
	import predriver_pkg::*;
	logic [FRAME_BITS-1:0]  cmd_word;
	logic [COUNT_WIDTH-1:0] bit_count;
	logic [FRAME_BITS-1:0]  status_word;
	modport main (input cmd_word, input bit_count, output status_word);
	modport link (output cmd_word, output bit_count, input status_word);
endinterface
`default_nettype wire

/* hw/spi_link.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_link
	import predriver_pkg::*;
(
	// serial pins
	input  wire logic sclk,
	input  wire logic link_rst,
	input  wire logic cs_n,
	input  wire logic si,
	output var  logic so,
	output var  logic so_oe_n,
	// core side
	link_if.link      bus
);

	logic                   fresh_fall;
	logic                   fresh_rise;
	logic [FRAME_BITS-1:0]  shift_in;
	logic [FRAME_BITS-1:0]  shift_out;
	logic [COUNT_WIDTH-1:0] count;

	// ======================================================================
	// frame start markers, held set while deselected
	always_ff @(negedge sclk or posedge cs_n or posedge link_rst) begin
		if (cs_n || link_rst)
			fresh_fall <= 1'b1;
		else
			fresh_fall <= 1'b0;
	end

	always_ff @(posedge sclk or posedge cs_n or posedge link_rst) begin
		if (cs_n || link_rst)
			fresh_rise <= 1'b1;
		else
			fresh_rise <= 1'b0;
	end

	// ======================================================================
	// receive shifter, falling edges, msb first
	always_ff @(negedge sclk or posedge link_rst) begin
		if (link_rst) begin
			shift_in <= 8'h00;
			count    <= 4'h0;
		end else if (!cs_n) begin // [R12]
			if (fresh_fall) begin
				shift_in <= {7'h00, si}; // [R13]
				count    <= 4'h1;
			end else begin
				shift_in <= {shift_in[FRAME_BITS-2:0], si}; // [R13]
				if (count != 4'hF)
					count <= count + 4'h1;
			end
		end
	end

	// ======================================================================
	// transmit shifter, new bit on each rising edge
	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst)
			shift_out <= 8'h00;
		else if (fresh_rise)
			shift_out <= bus.status_word; // [R15]
		else
			shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0}; // [R15]
	end

	// outputs; word is quiet once the frame has ended
	assign so           = shift_out[FRAME_BITS-1];
	assign so_oe_n      = cs_n | link_rst; // [R12] [R15]
	assign bus.cmd_word  = shift_in;
	assign bus.bit_count = count;

	// ======================================================================
	// checks
	so_float_a: assert property (@(posedge sclk) disable iff (link_rst) // [R15]
		cs_n |-> so_oe_n)
		else $error("serial output driven while deselected");

	shift_order_a: assert property (@(negedge sclk) // [R13]
		disable iff (link_rst)
		(!cs_n && !fresh_fall) |=>
		(shift_in[0] == $past(si) &&
		 shift_in[FRAME_BITS-1:1] == $past(shift_in[FRAME_BITS-2:0])))
		else $error("serial input not shifted msb first");

endmodule
`default_nettype wire

/* verif/spi_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
	// serial pins
	output var  logic       sclk,
	output var  logic       cs_n,
	output var  logic       si,
	input  wire logic       so_line,
	// received byte
	output var  logic [7:0] rx_byte,
	output var  logic       rx_done
);
	// ==========
	// idle levels
	initial begin
		sclk    = 1'b0; // clock idles low, still between frames
		cs_n    = 1'b1; // deselected by pull-up
		si      = 1'b0; // data idles low by pull-down
		rx_byte = 8'h00;
		rx_done = 1'b0;
	end

	// ==========
	// one frame; half sets the rate, nbits below 8 cuts it short
	task automatic xfer(input logic [7:0] tx, input int nbits,
			input int half);
		cs_n = 1'b0; // frame opens
		#100;
		for (int i = 0; i < nbits; i++) begin
			sclk = 1'b1; // device presents its next bit
			si   = tx[7 - i]; // most significant bit first
			#(half); // rate chosen by caller
			sclk    = 1'b0; // device samples si here
			rx_byte = {rx_byte[6:0], so_line}; // latched on fall
			#(half);
		end
		#100;
		cs_n    = 1'b1; // frame closes
		si      = 1'b0; // released line falls to pull-down
		rx_done = 1'b1;
		#1;
		rx_done = 1'b0;
		#200;
	endtask
endmodule
`default_nettype wire

/* verif/predriver_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module predriver_control_tb;
	import predriver_pkg::*;
	typedef struct {
		logic [12:0] val;
		logic [12:0] mask;
	} note_type;
	localparam logic [12:0] M_GATE = 13'h003F;
	localparam logic [12:0] M_INT  = 13'h0400;
	localparam logic [12:0] M_OE   = 13'h0800;
	logic        clock, srst, reset_n, supply_ok, en1, en2, oc_det;
	logic [2:0]  hi_n, lo, above, high_side_driver, low_side_driver, op;
	logic [6:0]  faults;
	logic        sclk, cs_n, si, so, so_oe_n, so_float, so_line;
	logic        gate_hiz, lvl_a, lvl_b, lvl_c, oc_stat, interrupt;
	logic        rx_done, int_exp;
	logic [7:0]  rx_byte;
	logic [12:0] pins;
	note_type    exp_pin[$], exp_spi[$], pn, sn;
	int          num_errors = 0, comparisons = 0;
	integer      seed;
	event        probe_ev;

	// ==========
	// design and controller
	predriver_control #(.DEAD_DEFAULT(DEAD_RESET)) dut (
		.clock(clock), .srst(srst), .reset_n(reset_n),
		.supply_ok(supply_ok), .drive_enable_first(en1),
		.drive_enable_second(en2), .phase_a_high_cmd_n(hi_n[0]),
		.phase_a_low_cmd(lo[0]), .phase_b_high_cmd_n(hi_n[1]),
		.phase_b_low_cmd(lo[1]), .phase_c_high_cmd_n(hi_n[2]),
		.phase_c_low_cmd(lo[2]), .phase_above_half(above),
		.overcurrent_detect(oc_det), .fault_detect(faults),
		.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
		.high_side_driver(high_side_driver),
		.low_side_driver(low_side_driver), .gate_hiz(gate_hiz),
		.phase_a_level_status(lvl_a), .phase_b_level_status(lvl_b),
		.phase_c_level_status(lvl_c), .overcurrent_status(oc_stat),
		.interrupt(interrupt));
	spi_master_model mcu (.sclk(sclk), .cs_n(cs_n), .si(si),
		.so_line(so_line), .rx_byte(rx_byte), .rx_done(rx_done));

	// floating serial output shows a toggling pattern
	always @(posedge clock) so_float <= ~so_float;
	assign so_line = so_oe_n ? so_float : so;
	assign pins = {gate_hiz, so_oe_n, interrupt, oc_stat, lvl_c, lvl_b,
		lvl_a, high_side_driver, low_side_driver};

	// clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ==========
	// checking
	task automatic check(input logic [12:0] seen, input logic [12:0] want);
		comparisons++;
		if (seen !== want) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	// watchers take the oldest note when a result shows
	always @(probe_ev) begin
		pn = exp_pin.pop_front();
		check(pins & pn.mask, pn.val & pn.mask);
	end
	always @(posedge rx_done) begin
		sn = exp_spi.pop_front();
		check({5'h00, rx_byte} & sn.mask, sn.val & sn.mask);
	end
	task automatic expect_pins(input logic [12:0] v, input logic [12:0] m);
		exp_pin.push_back('{v, m});
		->probe_ev;
		#1;
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clock);
	endtask
	function automatic logic [7:0] stat();
		return {int_exp, oc_det, above, 3'b000};
	endfunction
	// one frame; want is the status byte expected back under mask m
	task automatic spi(input logic [2:0] o, input logic [4:0] d, input int n,
			input int half, input logic [7:0] want, input logic [7:0] m);
		exp_spi.push_back('{{5'h00, want}, {5'h00, m}});
		mcu.xfer({o, d}, n, half);
		expect_pins(M_OE, M_OE); // output floats once deselected
		wait_clk(6);
	endtask
	task automatic end_sim();
		$display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge clock);
		num_errors++;
		end_sim();
	end

	// ==========
	// stimulus
	initial begin
		seed = 32'hcc02c828;
		{srst, reset_n, supply_ok, en1, en2} = 5'b11111;
		{hi_n, lo, above, op} = 12'hE00;
		{oc_det, so_float, int_exp} = 3'b000;
		faults = 7'h00;
		wait_clk(3);
		srst = 1'b0;
		wait_clk(3);
		// bootstrap order and deadtime per phase
		for (int p = 0; p < 3; p++) begin
			hi_n[p] = 1'b0;
			wait_clk(12);
			expect_pins(13'h0000, 13'h0008 << p);
			hi_n[p] = 1'b1;
			lo[p] = 1'b1;
			wait_clk(12);
			expect_pins(13'h0001 << p, 13'h0009 << p);
			hi_n[p] = 1'b0;
			wait_clk(6);
			expect_pins(13'h0000, 13'h0009 << p); // other side dropped
			wait_clk(6);
			expect_pins(13'h0008 << p, 13'h0009 << p);
			{hi_n[p], lo[p]} = 2'b10;
		end
		$display("test phases done");
		// each enable forces gates off; port keeps working
		for (int e = 0; e < 2; e++) begin
			lo = 3'b111;
			wait_clk(12);
			{lo, hi_n} = 6'h00;
			wait_clk(12);
			expect_pins(13'h0038, M_GATE);
			if (e == 0) en1 = 1'b0;
			else en2 = 1'b0;
			#2;
			expect_pins(13'h0000, M_GATE);
			spi(3'h0, 5'h00, 8, 16, stat(), 8'hFF);
			{en1, en2} = 2'b11;
			wait_clk(12);
			expect_pins(13'h0000, M_GATE); // arming lost with the enables; high sides stay off until a low side pulse
			hi_n = 3'b111;
		end
		$display("test enables done");
		// status pins and status byte
		for (int i = 0; i < 4; i++) begin
			{above, oc_det} = 4'($random(seed));
			int_exp = int_exp | oc_det;
			wait_clk(6);
			expect_pins({3'h0, oc_det, above, 6'h00}, 13'h03C0);
			spi(3'h0, 5'h00, 8, (i == 0) ? 100 : 16, stat(), 8'hFF);
		end
		oc_det = 1'b0;
		spi(OP_CLEAR_INT, 5'h00, 8, 16, 8'h00, 8'h00);
		expect_pins(13'h0000, M_INT);
		$display("test status done");
		// latched interrupt, short frame, clear
		faults = 7'h01;
		wait_clk(2);
		faults = 7'h00;
		wait_clk(4);
		expect_pins(M_INT, M_INT); // held after fault leaves
		spi(OP_CLEAR_INT, 5'h00, 7, 16, 8'h00, 8'h00);
		expect_pins(M_INT, M_INT); // short frame ignored
		spi(OP_CLEAR_INT, 5'h00, 8, 16, 8'h80, 8'h80);
		expect_pins(13'h0000, M_INT);
		// every source blocked by its mask bit
		for (int s = 0; s < 8; s++) begin
			op = s[2] ? OP_MASK_SECOND : OP_MASK_FIRST;
			spi(op, {1'b0, 4'hF ^ (4'h1 << s[1:0])}, 8, 16, 8'h00, 8'h00);
			{faults, oc_det} = 8'h01 << s;
			wait_clk(4);
			expect_pins(13'h0000, M_INT); // blocked source
			spi(op, 5'h0F, 8, 16, 8'h00, 8'h00);
			expect_pins(M_INT, M_INT); // source enabled again
			{faults, oc_det} = 8'h00;
			spi(OP_CLEAR_INT, 5'h00, 8, 16, 8'h00, 8'h00);
		end
		$display("test interrupt done");
		// programmed deadtime of zero
		spi(OP_DEADTIME, 5'h00, 8, 16, 8'h00, 8'h00);
		lo[0] = 1'b1;
		wait_clk(6);
		expect_pins(13'h0001, M_GATE);
		// reset pin
		faults = 7'h01;
		lo = 3'b111;
		wait_clk(12);
		{faults, reset_n} = 8'h00;
		#2;
		expect_pins(M_OE, M_OE | M_GATE); // outputs drop at once
		wait_clk(3);
		expect_pins(13'h0000, M_INT); // logic reset inside 77 ns
		wait_clk(1); // hold the pin low long enough for the reset check
		{reset_n, lo} = 4'h8;
		wait_clk(4);
		// supply below threshold
		supply_ok = 1'b0;
		#2;
		expect_pins(13'h1800, 13'h183F);
		spi(OP_MASK_FIRST, 5'h00, 8, 16, 8'h00, 8'h00);
		supply_ok = 1'b1;
		wait_clk(4);
		oc_det = 1'b1;
		wait_clk(6);
		expect_pins(M_INT, M_INT); // mask write was ignored
		oc_det = 1'b0;
		$display("test resets done");
		end_sim();
	end
endmodule
`default_nettype wire
